// >>> rtl/mfbrp_flash.sv
// Purpose: flash end of the muxed read port, async and burst reads
// Assumes: link pins asynchronous, sampled through two flip-flops
// Notes:   array content is a fixed function of the word address
// Operation
// - host presents address with avd, cs low
// - async address caught at avd rising edge
// - host lowers oe only after avd high
// - word driven on all 16 lines after oe
// - host keeps flash clock still in async
// - async after reset; burst latches on edge
// - host configures wait states before clocking
// - first word after latency, then one/edge
// - burst outputs change only on rising edges
// - ready flag marks first valid burst word
// - line-boundary waits when start + waits exceed 9
// - host latches burst address avd low
// - host advances burst with oe, avd high
// - cs high or reset floats bus, ready
// - avd low on edge restarts burst
// - nine waits: k waits before D8
// - eight waits: k-1 waits before D8
// - seven waits: k-2 waits before D8
// - six waits: k-3 waits before D8
// - continuous burst wraps to address zero
// - two 16-bit config registers reset default
`timescale 1ns/1ps
module mfbrp_flash (
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset,
    mfbrp_link_if.flash      link,
    input  wire logic        i_cfg_wr,
    input  wire logic        i_cfg_sel,
    input  wire logic [15:0] i_cfg_data,
    output logic      [15:0] o_cfg0,
    output logic      [15:0] o_cfg1,
    output logic             o_burst_active
);
    // ----------------------------------------------------------------
    // pin synchroniser
    // ----------------------------------------------------------------
    logic [28:0] s1_q;
    logic [28:0] s2_q;
    logic        fclk_p_q;
    logic        avd_p_q;

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            s1_q <= mfbrp_pkg::DEV_SYNC_RST;
            s2_q <= mfbrp_pkg::DEV_SYNC_RST;
        end
        else
        begin
            s1_q <= {link.rst_n, link.cs_n, link.oe_n, link.we_n,
                     link.avd_n, link.fclk, link.upper, link.dq};
            s2_q <= s1_q;
        end
    end

    logic        rst_n_s;
    logic        cs_n_s;
    logic        oe_n_s;
    logic        we_n_s;
    logic        avd_n_s;
    logic        fclk_s;
    logic [6:0]  upper_s;
    logic [15:0] dq_s;
    assign rst_n_s = s2_q[28];
    assign cs_n_s  = s2_q[27];
    assign oe_n_s  = s2_q[26];
    assign we_n_s  = s2_q[25];
    assign avd_n_s = s2_q[24];
    assign fclk_s  = s2_q[23];
    assign upper_s = s2_q[22:16];
    assign dq_s    = s2_q[15:0];

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            fclk_p_q <= 1'b0;
            avd_p_q  <= 1'b1;
        end
        else
        begin
            fclk_p_q <= fclk_s;
            avd_p_q  <= avd_n_s;
        end
    end

    // ----------------------------------------------------------------
    // events
    // ----------------------------------------------------------------
    mfbrp_pkg::mfbrp_dev_state_t state_q;
    logic selected;
    logic clk_edge;
    logic start_burst;
    logic start_async;
    logic in_burst;
    logic [22:0] addr_q;
    // only rising edges count; falling edges are never looked at
    assign clk_edge    = fclk_s & ~fclk_p_q;
    assign selected    = ~cs_n_s & rst_n_s;
    assign start_burst = selected & clk_edge & ~avd_n_s & we_n_s;
    assign start_async = selected & avd_n_s & ~avd_p_q & we_n_s &
                         (state_q == mfbrp_pkg::D_IDLE ||
                          state_q == mfbrp_pkg::D_ASYNC);
    assign in_burst    = state_q == mfbrp_pkg::D_LAT ||
                         state_q == mfbrp_pkg::D_STREAM ||
                         state_q == mfbrp_pkg::D_ALIGN;

    // ----------------------------------------------------------------
    // configuration
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset || !rst_n_s)
        begin
            o_cfg0 <= mfbrp_pkg::CFG0_RST;
            o_cfg1 <= mfbrp_pkg::CFG1_RST;
        end
        else if (i_cfg_wr)
        begin
            if (i_cfg_sel)
                o_cfg1 <= i_cfg_data;
            else
                o_cfg0 <= i_cfg_data;
        end
    end

    // settings outside 2..9 are clamped; line crossings stall when start + waits exceed 9
    logic [3:0] ws_raw;
    logic [3:0] ws;
    logic [4:0] ins_sum;
    logic [3:0] ins_calc;
    assign ws_raw = o_cfg0[mfbrp_pkg::CFG_WS_LSB +: 4];

    always_comb
    begin
        if (ws_raw < 4'(mfbrp_pkg::WS_MIN))
            ws = 4'(mfbrp_pkg::WS_MIN);
        else if (ws_raw > 4'(mfbrp_pkg::WS_MAX))
            ws = 4'(mfbrp_pkg::WS_MAX);
        else
            ws = ws_raw;
        // waits before D8 = start position + waits - 9, never negative
        ins_sum = {2'b00, dq_s[2:0]} + {1'b0, ws};
        if (ins_sum > 5'(mfbrp_pkg::WS_MAX))
            ins_calc = 4'(ins_sum - 5'(mfbrp_pkg::WS_MAX));
        else
            ins_calc = 4'h0;
    end

    // ----------------------------------------------------------------
    // read state machine
    // ----------------------------------------------------------------
    logic [3:0] lat_q;
    logic [3:0] ins_q;
    logic       emit;

    always_comb
    begin
        emit = 1'b0;
        if (selected && clk_edge && !start_burst)
        begin
            unique case (state_q)
                mfbrp_pkg::D_LAT:    emit = lat_q == 4'h1;
                mfbrp_pkg::D_STREAM: emit = !(ins_q != 4'h0 &&
                                              addr_q[2:0] == 3'h0);
                mfbrp_pkg::D_ALIGN:  emit = ins_q == 4'h0;
                default:             emit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset || !selected)
            state_q <= mfbrp_pkg::D_IDLE;
        else if (start_burst)
            state_q <= mfbrp_pkg::D_LAT;
        else if (start_async)
            state_q <= mfbrp_pkg::D_ASYNC;
        else if (clk_edge && in_burst)
        begin
            if (emit)
                state_q <= mfbrp_pkg::D_STREAM;
            else if (state_q == mfbrp_pkg::D_STREAM)
                state_q <= mfbrp_pkg::D_ALIGN;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            lat_q <= 4'h0;
            ins_q <= 4'h0;
        end
        else if (start_burst)
        begin
            lat_q <= ws;
            ins_q <= ins_calc;
        end
        else if (selected && clk_edge && in_burst)
        begin
            if (state_q == mfbrp_pkg::D_LAT)
                lat_q <= lat_q - 4'h1;
            else if (!emit && ins_q != 4'h0)
                ins_q <= ins_q - 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // address counter and array
    // ----------------------------------------------------------------
    function automatic logic [15:0] array_word(input logic [22:0] a);
        array_word = a[15:0] ^ {a[22:16], 9'h000};
    endfunction

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            addr_q <= 23'h000000;
        else if (start_burst || start_async)
            addr_q <= {upper_s, dq_s};
        else if (emit)
            addr_q <= addr_q + 23'h000001;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    logic [15:0] word_q;
    logic        rdy_q;
    logic [1:0]  oe_cnt_q;

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            word_q <= 16'h0000;
        else if (start_async || emit)
            word_q <= array_word(start_async ? {upper_s, dq_s} : addr_q);
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset || !selected || start_burst)
            rdy_q <= 1'b0;
        else if (clk_edge && in_burst)
            rdy_q <= emit;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset || oe_n_s || state_q != mfbrp_pkg::D_ASYNC)
            oe_cnt_q <= 2'h0;
        else if (oe_cnt_q != 2'(mfbrp_pkg::T_OE_CYC))
            oe_cnt_q <= oe_cnt_q + 2'h1;
    end

    assign link.dev_dq_o  = word_q;
    assign link.dev_dq_oe = selected & ~oe_n_s &
                            ((state_q == mfbrp_pkg::D_ASYNC &&
                              oe_cnt_q == 2'(mfbrp_pkg::T_OE_CYC)) ||
                             state_q == mfbrp_pkg::D_STREAM ||
                             state_q == mfbrp_pkg::D_ALIGN);
    assign link.rdy_o     = rdy_q;
    assign link.rdy_oe    = selected & in_burst;
    assign o_burst_active = in_burst;
endmodule

// >>> rtl/mfbrp_host.sv
// Purpose: memory controller end, classic wishbone slave to software
// Assumes: flash clock made here by dividing the reference clock
// Notes:   one data word register, software must keep pace or lose words
//
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module mfbrp_host (
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [31:0] i_wb_dat,
    input  wire logic [3:0]  i_wb_sel,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    output logic      [15:0] o_word,
    output logic             o_word_valid,
    mfbrp_link_if.host       link
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    mfbrp_pkg::mfbrp_host_state_t st_q;
    logic [22:0] addr_q;
    logic [7:0]  count_q;
    logic [7:0]  got_q;
    logic        burst_q;
    logic        go_q;
    logic        done_q;
    logic        take;
    logic        wr;
    logic        finish;
    // write lands on the edge where the master sees ack high
    assign wr = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack;
    assign take = go_q & (st_q == mfbrp_pkg::H_IDLE);

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            o_wb_ack <= 1'b0;
        else
            o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            addr_q  <= 23'h000000;
            count_q <= 8'h01;
            burst_q <= 1'b0;
        end
        else if (wr)
        begin
            if (i_wb_adr == mfbrp_pkg::OFF_ADDR)
            begin
                if (i_wb_sel[0])
                    addr_q[7:0] <= i_wb_dat[7:0];
                if (i_wb_sel[1])
                    addr_q[15:8] <= i_wb_dat[15:8];
                if (i_wb_sel[2])
                    addr_q[22:16] <= i_wb_dat[22:16];
            end
            if (i_wb_adr == mfbrp_pkg::OFF_COUNT && i_wb_sel[0])
                count_q <= i_wb_dat[7:0];
            if (i_wb_adr == mfbrp_pkg::OFF_CTRL && i_wb_sel[0])
                burst_q <= i_wb_dat[mfbrp_pkg::CTRL_BURST_BIT];
        end
    end

    // go stays pending until the sequencer takes it; a restart wins
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            go_q <= 1'b0;
        else if (wr && i_wb_adr == mfbrp_pkg::OFF_CTRL && i_wb_sel[0] &&
                 i_wb_dat[mfbrp_pkg::CTRL_GO_BIT])
            go_q <= 1'b1;
        else if (take)
            go_q <= 1'b0;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            done_q <= 1'b0;
        else if (finish)
            done_q <= 1'b1;
        else if (take)
            done_q <= 1'b0;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            o_wb_dat <= 32'h00000000;
        else
        begin
            unique case (i_wb_adr)
                mfbrp_pkg::OFF_CTRL:   o_wb_dat <= {30'h0, burst_q, go_q};
                mfbrp_pkg::OFF_ADDR:   o_wb_dat <= {9'h000, addr_q};
                mfbrp_pkg::OFF_COUNT:  o_wb_dat <= {24'h000000, count_q};
                mfbrp_pkg::OFF_STATUS: o_wb_dat <= {30'h0, done_q,
                                        st_q != mfbrp_pkg::H_IDLE};
                mfbrp_pkg::OFF_DATA:   o_wb_dat <= {8'h00, got_q, o_word};
                default:               o_wb_dat <= 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pin synchroniser
    // ----------------------------------------------------------------
    logic [16:0] y1_q;
    logic [16:0] y2_q;
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            y1_q <= mfbrp_pkg::HOST_SYNC_RST;
            y2_q <= mfbrp_pkg::HOST_SYNC_RST;
        end
        else
        begin
            y1_q <= {link.rdy, link.dq};
            y2_q <= y1_q;
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    logic [7:0] tmr_q;
    logic [3:0] ph_q;
    logic       fclk_q;
    logic       rise;
    logic       fall;
    logic       bclk;
    logic       sample;
    assign bclk   = st_q == mfbrp_pkg::H_B_ADDR || st_q == mfbrp_pkg::H_B_RUN;
    assign rise   = bclk & ph_q == 4'(mfbrp_pkg::FCLK_HALF_CYC - 1) & ~fclk_q;
    assign fall   = bclk & ph_q == 4'(mfbrp_pkg::FCLK_HALF_CYC - 1) & fclk_q;
    // data is sampled just before the rise that would replace it
    assign sample = rise & st_q == mfbrp_pkg::H_B_RUN & y2_q[16];
    assign finish = (st_q == mfbrp_pkg::H_A_OE && tmr_q == 8'h00) ||
                    (sample && got_q + 8'h01 >= count_q);

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset || !bclk || (rise && finish))
        begin
            ph_q   <= 4'h0;
            fclk_q <= 1'b0;
        end
        else if (ph_q == 4'(mfbrp_pkg::FCLK_HALF_CYC - 1))
        begin
            ph_q   <= 4'h0;
            fclk_q <= ~fclk_q;
        end
        else
            ph_q <= ph_q + 4'h1;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset || take)
            got_q <= 8'h00;
        else if (sample || finish)
            got_q <= got_q + 8'h01;
    end

    always_ff @(posedge i_ref_clk)
    begin
        o_word_valid <= 1'b0;
        if (i_reset)
            o_word <= 16'h0000;
        else if (sample || (st_q == mfbrp_pkg::H_A_OE && tmr_q == 8'h00))
        begin
            o_word       <= y2_q[15:0];
            o_word_valid <= 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            st_q            <= mfbrp_pkg::H_IDLE;
            tmr_q           <= 8'h00;
            link.cs_n       <= 1'b1;
            link.oe_n       <= 1'b1;
            link.avd_n      <= 1'b1;
            link.upper      <= 7'h00;
            link.host_dq_o  <= 16'h0000;
            link.host_dq_oe <= 1'b0;
        end
        else
        begin
            if (tmr_q != 8'h00)
                tmr_q <= tmr_q - 8'h01;
            unique case (st_q)
                mfbrp_pkg::H_IDLE:
                    if (take)
                    begin
                        link.cs_n       <= 1'b0;
                        link.oe_n       <= 1'b1;
                        link.avd_n      <= 1'b0;
                        link.upper      <= addr_q[22:16];
                        link.host_dq_o  <= addr_q[15:0];
                        link.host_dq_oe <= 1'b1;
                        tmr_q <= 8'(mfbrp_pkg::ADDR_PHASE_CYC);
                        st_q  <= burst_q ? mfbrp_pkg::H_B_ADDR
                                         : mfbrp_pkg::H_A_ADDR;
                    end
                mfbrp_pkg::H_A_ADDR:
                    if (tmr_q == 8'h00)
                    begin
                        link.avd_n <= 1'b1;
                        tmr_q <= 8'(mfbrp_pkg::ADDR_PHASE_CYC);
                        st_q  <= mfbrp_pkg::H_A_HOLD;
                    end
                mfbrp_pkg::H_A_HOLD:
                    if (tmr_q == 8'h00)
                    begin
                        link.host_dq_oe <= 1'b0;
                        link.oe_n       <= 1'b0;
                        tmr_q <= 8'(mfbrp_pkg::HOST_OE_WAIT_CYC);
                        st_q  <= mfbrp_pkg::H_A_OE;
                    end
                mfbrp_pkg::H_B_ADDR:
                    if (fall)
                    begin
                        link.avd_n      <= 1'b1;
                        link.host_dq_oe <= 1'b0;
                        link.oe_n       <= 1'b0;
                        st_q <= mfbrp_pkg::H_B_RUN;
                    end
                mfbrp_pkg::H_B_RUN:
                    if (rise && finish)
                        st_q <= mfbrp_pkg::H_END;
                default:
                    ;
            endcase
            if (st_q == mfbrp_pkg::H_A_OE && tmr_q == 8'h00)
                st_q <= mfbrp_pkg::H_END;
            if (st_q == mfbrp_pkg::H_END && tmr_q == 8'h00)
                st_q <= mfbrp_pkg::H_IDLE;
            if (finish)
            begin
                link.cs_n  <= 1'b1;
                link.oe_n  <= 1'b1;
                tmr_q <= 8'(mfbrp_pkg::END_CYC);
            end
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        link.we_n  <= 1'b1;
        link.rst_n <= ~i_reset;
    end
    assign link.fclk = fclk_q;
endmodule

// >>> rtl/mfbrp_link_if.sv
// Purpose: pins between memory controller and flash
// Assumes: enables resolve the shared lines, undriven lines read low
// Notes:   no clocking block, both ends run on the reference clock
`timescale 1ns/1ps
interface mfbrp_link_if;
    logic        cs_n;
    logic        oe_n;
    logic        we_n;
    logic        avd_n;
    logic        fclk;
    logic        rst_n;
    logic [6:0]  upper;
    logic [15:0] host_dq_o;
    logic        host_dq_oe;
    logic [15:0] dev_dq_o;
    logic        dev_dq_oe;
    logic        rdy_o;
    logic        rdy_oe;
    logic [15:0] dq;
    logic        rdy;
    assign dq  = dev_dq_oe ? dev_dq_o : (host_dq_oe ? host_dq_o : 16'h0000);
    assign rdy = rdy_oe ? rdy_o : 1'b0;
    modport host (output cs_n, oe_n, we_n, avd_n, fclk, rst_n, upper,
                  output host_dq_o, host_dq_oe, input dq, rdy);
    modport flash (input cs_n, oe_n, we_n, avd_n, fclk, rst_n, upper,
                   input dq, output dev_dq_o, dev_dq_oe, rdy_o, rdy_oe);
endinterface

// >>> rtl/mfbrp_pkg.sv
// Purpose: shared constants and types of the muxed flash read port
// Assumes: one reference clock at 25 MHz
// Notes:   word address is 23 bits, upper lines carry bits 22..16
package mfbrp_pkg;
    // ----------------------------------------------------------------
    // widths and timing
    // ----------------------------------------------------------------
    localparam int ADDR_W           = 23;
    localparam int UPPER_W          = 7;
    localparam int DATA_W           = 16;
    localparam int SYNC_W           = 29;
    localparam int CLK_PERIOD_NS    = 40;
    localparam int T_OE_NS          = 80;
    localparam int T_OE_CYC         =
        (T_OE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FCLK_HALF_CYC    = 8;
    localparam int ADDR_PHASE_CYC   = 4;
    localparam int HOST_OE_WAIT_CYC = 12;
    localparam int END_CYC          = 2;
    localparam int WS_MIN           = 2;
    localparam int WS_MAX           = 9;
    // ----------------------------------------------------------------
    // reset values and fields
    // ----------------------------------------------------------------
    localparam logic [15:0] CFG0_RST     = 16'h0009;
    localparam logic [15:0] CFG1_RST     = 16'h0000;
    localparam int          CFG_WS_LSB   = 0;
    localparam logic [28:0] DEV_SYNC_RST = 29'h1f000000;
    localparam logic [16:0] HOST_SYNC_RST = 17'h00000;
    // ----------------------------------------------------------------
    // controller registers
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_ADDR    = 8'h04;
    localparam logic [7:0] OFF_COUNT   = 8'h08;
    localparam logic [7:0] OFF_STATUS  = 8'h0c;
    localparam logic [7:0] OFF_DATA    = 8'h10;
    localparam int CTRL_GO_BIT    = 0;
    localparam int CTRL_BURST_BIT = 1;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_DONE_BIT  = 1;
    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        D_IDLE   = 5'h01,
        D_ASYNC  = 5'h02,
        D_LAT    = 5'h04,
        D_STREAM = 5'h08,
        D_ALIGN  = 5'h10
    } mfbrp_dev_state_t;
    typedef enum logic [6:0] {
        H_IDLE   = 7'h01,
        H_A_ADDR = 7'h02,
        H_A_HOLD = 7'h04,
        H_A_OE   = 7'h08,
        H_B_ADDR = 7'h10,
        H_B_RUN  = 7'h20,
        H_END    = 7'h40
    } mfbrp_host_state_t;
endpackage

// >>> test/mfbrp_checker.sv
// Purpose: link pin checks between controller and flash
// Assumes: one clock, sync reset
// Notes:   windows leave slack for the pin synchronisers
`timescale 1ns/1ps
module mfbrp_checker (
    input wire logic        i_ref_clk,
    input wire logic        i_reset,
    input wire logic        cs_n,
    input wire logic        oe_n,
    input wire logic        we_n,
    input wire logic        avd_n,
    input wire logic        fclk,
    input wire logic        host_dq_oe,
    input wire logic        dev_dq_oe,
    input wire logic        rdy_oe,
    input wire logic        rdy,
    input wire logic [15:0] dq
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    property p_we; we_n; endproperty
    property p_float; cs_n [*5] |-> !dev_dq_oe && !rdy_oe; endproperty
    property p_oe_avd; $fell(oe_n) |-> avd_n; endproperty
    property p_excl; !(dev_dq_oe && host_dq_oe); endproperty
    property p_rdy_lat; $rose(rdy_oe) |-> !rdy; endproperty
    // low phase is 8 cycles, so five back means no rise lately
    property p_rise;
        rdy_oe && dev_dq_oe && $past(dev_dq_oe) && !fclk && !$past(fclk, 5)
        |-> $stable(dq);
    endproperty
    property p_avd_drv; !avd_n && !cs_n |-> host_dq_oe && oe_n; endproperty
    property p_rst; $past(i_reset) |-> !dev_dq_oe && !rdy_oe; endproperty
    a_we: assert property (p_we) else $error("write enable low");
    a_float: assert property (p_float) else $error("drive when off");
    a_oe_avd: assert property (p_oe_avd) else $error("oe before avd");
    a_excl: assert property (p_excl) else $error("bus contention");
    a_rdy_lat: assert property (p_rdy_lat) else $error("ready early");
    a_rise: assert property (p_rise) else $error("data off rise");
    a_avd_drv: assert property (p_avd_drv) else $error("no address");
    a_rst: assert property (p_rst) else $error("drive in reset");
    c_oe: cover property ($fell(oe_n));
    c_rdy: cover property ($rose(rdy));
    c_end: cover property ($rose(cs_n));
endmodule

// >>> test/mfbrp_tb_top.sv
// Purpose: both ends joined, driven over wishbone
// Assumes: 25 MHz clock, sync reset
// Notes:   words taken from the word port, gaps timed in cycles
`timescale 1ns/1ps
module mfbrp_tb_top;
    logic        i_ref_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat;
    logic        ack, wv, ba, cfg_wr = 1'b0;
    logic [15:0] word, cfg_data = 16'h0009, cfg0, cfg1;
    int          error_cnt = 0, n_compared = 0, cyc_n = 0;
    int          t_q[$];
    logic [15:0] w_q[$];
    always #20 i_ref_clk = ~i_ref_clk;
    mfbrp_link_if i_mfbrp_link_if();
    mfbrp_host i_mfbrp_host (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_dat(wdat), .i_wb_sel(4'hf), .o_wb_dat(rdat), .o_wb_ack(ack),
        .o_word(word), .o_word_valid(wv), .link(i_mfbrp_link_if.host));
    mfbrp_flash i_mfbrp_flash (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .link(i_mfbrp_link_if.flash), .i_cfg_wr(cfg_wr), .i_cfg_sel(1'b0),
        .i_cfg_data(cfg_data), .o_cfg0(cfg0), .o_cfg1(cfg1),
        .o_burst_active(ba));
    mfbrp_checker i_mfbrp_checker (.i_ref_clk(i_ref_clk),
        .i_reset(i_reset), .cs_n(i_mfbrp_link_if.cs_n),
        .oe_n(i_mfbrp_link_if.oe_n), .we_n(i_mfbrp_link_if.we_n),
        .avd_n(i_mfbrp_link_if.avd_n), .fclk(i_mfbrp_link_if.fclk),
        .host_dq_oe(i_mfbrp_link_if.host_dq_oe),
        .dev_dq_oe(i_mfbrp_link_if.dev_dq_oe),
        .rdy_oe(i_mfbrp_link_if.rdy_oe), .rdy(i_mfbrp_link_if.rdy),
        .dq(i_mfbrp_link_if.dq));
    always @(posedge i_ref_clk)
    begin
        cyc_n <= cyc_n + 1;
        if (wv === 1'b1)
        begin
            w_q.push_back(word);
            t_q.push_back(cyc_n);
        end
    end
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    function automatic logic [15:0] f(input logic [22:0] a);
        return a[15:0] ^ {a[22:16], 9'h000};
    endfunction
    task automatic close_out();
        if (error_cnt == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge i_ref_clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge i_ref_clk); while (ack !== 1'b1 && ++n < 50);
        q = rdat;
        cyc <= 1'b0;
        if (n >= 50)
        begin
            error_cnt++;
            close_out();
        end
    endtask
    // burst gaps: one flash clock is 16 cycles, waits add one each
    task automatic run(input logic [22:0] a, input int ws, input logic b);
        logic [31:0] q;
        int          i, p;
        i = 0;
        p = a[2:0];
        if (b)
        begin
            @(posedge i_ref_clk);
            cfg_wr <= 1'b1;
            cfg_data <= 16'(ws);
            @(posedge i_ref_clk);
            cfg_wr <= 1'b0;
        end
        w_q.delete();
        t_q.delete();
        wb(1'b1, 8'h04, {9'h000, a}, q);
        wb(1'b1, 8'h08, 32'h0000000a, q);
        wb(1'b1, 8'h00, {30'h0, b, 1'b1}, q);
        do wb(1'b0, 8'h0c, 32'h0, q); while (q[1] !== 1'b1 && ++i < 1000);
        if (i >= 1000)
        begin
            error_cnt++;
            close_out();
        end
        wb(1'b0, 8'h10, 32'h0, q);
        chk(ba, 1'b0);
        chk(q[15:0], f(23'(a + (b ? 9 : 0))));
        chk(w_q.size(), b ? 10 : 1);
        foreach (w_q[k]) chk(w_q[k], f(23'(a + k)));
        if (b) chk(t_q[8-p] - t_q[7-p], 16 * (1 + ((p + ws > 9) ? p + ws - 9 : 0)));
    endtask
    initial
    begin
        repeat (2) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        repeat (8) @(posedge i_ref_clk);
        chk(cfg0, 16'h0009);
        chk(cfg1, 16'h0000);
        run(23'h123456, 9, 1'b0);
        for (int w = 6; w <= 9; w++)
            run(23'h00007d, w, 1'b1);
        run(23'h7ffffd, 2, 1'b1);
        close_out();
    end
endmodule
